/* src/rcc_reset_cause_control.sv */
// Function
// - Eight-bit register, fixed field order
// - Priority bit selects multi-level interrupt mode
// - Software brown-out bit only under config 01
// - Bit five reads zero, writes ignored
// - Reset instruction clears its flag
// - Watchdog flag set by power-up/clear/sleep, cleared timeout
// - Power-on/brown-out reset load flags, clear priority
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rcc_reset_cause_control
  import rcc_pkg::*;
(
  input  wire logic                  sys_clk_i,                  // 50 MHz system clock
  input  wire logic                  rst_i,                      // Power-on reset, async high
  input  wire logic [RCC_ADDR_W-1:0] addr_i,                     // Register address
  input  wire logic [7:0]            wdata_i,                    // Write data
  input  wire logic                  wr_i,                       // Write strobe
  input  wire logic                  rd_i,                       // Read strobe
  output logic      [7:0]            rdata_o,                    // Read data, cycle after strobe
  input  wire logic [1:0]            brownout_config_field_i,    // Brown-out configuration
  input  wire logic                  brownout_reset_i,           // Brown-out reset pulse
  input  wire logic                  reset_instruction_i,        // Reset instruction pulse
  input  wire logic                  other_reset_i,              // Any other reset pulse
  input  wire logic                  watchdog_timeout_i,         // Watchdog time-out pulse
  input  wire logic                  watchdog_clear_instruction_i, // Watchdog clear pulse
  input  wire logic                  sleep_instruction_i,        // Sleep instruction pulse
  output logic                       priority_levels_enable_o,   // Multi-level interrupts
  output logic                       brownout_detect_enable_o    // Software brown-out enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Software bit only counts under the software config value
  function automatic logic sw_gate(input logic bit_v, input logic [1:0] cfg);
    return bit_v & (cfg == RCC_CFG_SW);
  endfunction

  // Register image as software sees it
  function automatic logic [7:0] reg_image(input rcc_state_t s, input logic [1:0] cfg);
    logic [7:0] v;
    v                 = 8'h00;
    v[RCC_PRIO_BIT]   = s.priority_levels_enable;
    v[RCC_SWBO_BIT]   = sw_gate(s.software_brownout_enable, cfg);
    v[RCC_UNUSED_BIT] = 1'b0;
    v[RCC_RSTI_BIT]   = s.reset_instruction_flag;
    v[RCC_WDTO_BIT]   = s.watchdog_timeout_flag;
    v[RCC_PDN_BIT]    = s.power_down_flag;
    v[RCC_PON_BIT]    = s.power_on_flag;
    v[RCC_BRN_BIT]    = s.brownout_flag;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  rcc_state_t st_ff;   // Registered state
  rcc_state_t nxt_st;  // Next state
  logic       hit;     // Address decode

  assign hit = (addr_i == RCC_REG_ADDR);

  // Next-state logic; later assignments win, so hardware events sit after
  // software writes and a set from hardware is never lost to a write
  always_comb begin
    nxt_st = st_ff;
    // Software writes: read-only flags and bit five are skipped
    if (wr_i && hit) begin
      nxt_st.priority_levels_enable   = wdata_i[RCC_PRIO_BIT];
      nxt_st.software_brownout_enable = wdata_i[RCC_SWBO_BIT];
      nxt_st.reset_instruction_flag   = wdata_i[RCC_RSTI_BIT];
      nxt_st.power_on_flag            = wdata_i[RCC_PON_BIT];
      nxt_st.brownout_flag            = wdata_i[RCC_BRN_BIT];
    end
    // Watchdog clear re-arms both flags
    if (watchdog_clear_instruction_i) begin
      nxt_st.watchdog_timeout_flag = 1'b1;
      nxt_st.power_down_flag       = 1'b1;
    end
    // Sleep arms time-out flag, marks power-down
    if (sleep_instruction_i) begin
      nxt_st.watchdog_timeout_flag = 1'b1;
      nxt_st.power_down_flag       = 1'b0;
    end
    // Time-out beats a same-cycle clear or sleep
    if (watchdog_timeout_i) begin
      nxt_st.watchdog_timeout_flag = 1'b0;
    end
    // Any device reset drops priority mode
    if (other_reset_i || reset_instruction_i) begin
      nxt_st.priority_levels_enable = 1'b0;
    end
    // Reset instruction leaves its mark
    if (reset_instruction_i) begin
      nxt_st.reset_instruction_flag = 1'b0;
    end
    // Brown-out reset reloads like power-on, power-on flag kept
    if (brownout_reset_i) begin
      nxt_st.priority_levels_enable   = RCC_RST_PRIO;
      nxt_st.software_brownout_enable = RCC_RST_SWBO;
      nxt_st.reset_instruction_flag   = RCC_RST_RSTI;
      nxt_st.watchdog_timeout_flag    = RCC_RST_WDTO;
      nxt_st.power_down_flag          = RCC_RST_PDN;
      nxt_st.brownout_flag            = RCC_RST_BRN;
      // A reset aborts a same-cycle write, so the power-on flag holds
      nxt_st.power_on_flag            = st_ff.power_on_flag;
    end
    // Read data valid only the cycle after a read
    if (rd_i && hit) begin
      nxt_st.rdata = reg_image(st_ff, brownout_config_field_i);
    end else begin
      nxt_st.rdata = 8'h00;
    end
  end

  // State register; async reset stands for a power-on reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff.priority_levels_enable   <= RCC_RST_PRIO;
      st_ff.software_brownout_enable <= RCC_RST_SWBO;
      st_ff.reset_instruction_flag   <= RCC_RST_RSTI;
      st_ff.watchdog_timeout_flag    <= RCC_RST_WDTO;
      st_ff.power_down_flag          <= RCC_RST_PDN;
      st_ff.power_on_flag            <= RCC_RST_PON;
      st_ff.brownout_flag            <= RCC_RST_BRN;
      st_ff.rdata                    <= RCC_RST_RDATA;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_o                  = st_ff.rdata;
  assign priority_levels_enable_o = st_ff.priority_levels_enable;
  // Gated live: config is static in practice, so no extra flop
  assign brownout_detect_enable_o =
    sw_gate(st_ff.software_brownout_enable, brownout_config_field_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_read_layout: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_i && hit |=> rdata_o == reg_image($past(st_ff), $past(brownout_config_field_i)))
    else $error("register read image wrong");

  a_prio_write: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_i && hit && !other_reset_i && !reset_instruction_i && !brownout_reset_i
    |=> priority_levels_enable_o == $past(wdata_i[RCC_PRIO_BIT]))
    else $error("priority enable did not follow write");

  a_swbo_gate: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_i && hit && brownout_config_field_i != RCC_CFG_SW |=> !rdata_o[RCC_SWBO_BIT])
    else $error("software brown-out bit not masked");

  a_bden_mask: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    brownout_config_field_i != RCC_CFG_SW |-> !brownout_detect_enable_o)
    else $error("brown-out enable not masked by config");

  a_rdata_idle: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !(rd_i && hit) |=> rdata_o == 8'h00)
    else $error("read data not idle");

  a_unused_zero: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ##1 !rdata_o[RCC_UNUSED_BIT])
    else $error("unused bit read nonzero");

  a_rsti_clear: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    reset_instruction_i && !brownout_reset_i |=> !st_ff.reset_instruction_flag)
    else $error("reset instruction flag not cleared");

  a_wdto_flag: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    watchdog_timeout_i && !brownout_reset_i |=> !st_ff.watchdog_timeout_flag ##1
    (st_ff.watchdog_timeout_flag == $past(watchdog_clear_instruction_i ||
     sleep_instruction_i || brownout_reset_i) || $past(watchdog_timeout_i)))
    else $error("watchdog time-out flag wrong");

  a_brownout_load: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    brownout_reset_i |=> !priority_levels_enable_o && st_ff.reset_instruction_flag &&
    st_ff.watchdog_timeout_flag && st_ff.power_down_flag && !st_ff.brownout_flag &&
    $stable(st_ff.power_on_flag))
    else $error("brown-out reset load wrong");

  a_reset_prio: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    other_reset_i || reset_instruction_i |=> !priority_levels_enable_o)
    else $error("priority enable survived a reset");

  a_ro_flags: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_i && hit && !(watchdog_clear_instruction_i || sleep_instruction_i ||
    watchdog_timeout_i || brownout_reset_i) |=> $stable(st_ff.watchdog_timeout_flag) &&
    $stable(st_ff.power_down_flag))
    else $error("software changed a read-only flag");

  a_wdclr_set: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    watchdog_clear_instruction_i && !sleep_instruction_i && !watchdog_timeout_i
    |=> st_ff.watchdog_timeout_flag && st_ff.power_down_flag)
    else $error("watchdog clear did not set flags");

  a_pdn_sleep: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    sleep_instruction_i && !watchdog_clear_instruction_i && !brownout_reset_i
    |=> !st_ff.power_down_flag)
    else $error("power-down flag not cleared by sleep");

endmodule : rcc_reset_cause_control

`default_nettype wire

/* src/rcc_pkg.sv */
// Shared constants for the reset cause and control register
package rcc_pkg;
  // Register bus geometry
  localparam int unsigned     RCC_ADDR_W     = 4;
  localparam logic [3:0]      RCC_REG_ADDR   = 4'h0;  // Single register at index zero
  // Field positions inside the 8-bit register
  localparam int unsigned     RCC_PRIO_BIT   = 7;
  localparam int unsigned     RCC_SWBO_BIT   = 6;
  localparam int unsigned     RCC_UNUSED_BIT = 5;
  localparam int unsigned     RCC_RSTI_BIT   = 4;
  localparam int unsigned     RCC_WDTO_BIT   = 3;
  localparam int unsigned     RCC_PDN_BIT    = 2;
  localparam int unsigned     RCC_PON_BIT    = 1;
  localparam int unsigned     RCC_BRN_BIT    = 0;
  // Brown-out configuration value that hands control to software
  localparam logic [1:0]      RCC_CFG_SW     = 2'h1;
  // Values after a power-on reset
  localparam logic            RCC_RST_PRIO   = 1'b0;
  localparam logic            RCC_RST_SWBO   = 1'b1;  // Masked unless config selects software
  localparam logic            RCC_RST_RSTI   = 1'b1;
  localparam logic            RCC_RST_WDTO   = 1'b1;
  localparam logic            RCC_RST_PDN    = 1'b1;
  localparam logic            RCC_RST_PON    = 1'b0;
  localparam logic            RCC_RST_BRN    = 1'b0;
  localparam logic [7:0]      RCC_RST_RDATA  = 8'h00;

  // Whole state of the block
  typedef struct packed {
    logic       priority_levels_enable;
    logic       software_brownout_enable;
    logic       reset_instruction_flag;
    logic       watchdog_timeout_flag;
    logic       power_down_flag;
    logic       power_on_flag;
    logic       brownout_flag;
    logic [7:0] rdata;
  } rcc_state_t;
endpackage : rcc_pkg

/* sim/rcc_reset_cause_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rcc_reset_cause_control_bench;
  import rcc_pkg::*;
  logic                  sys_clk_i;   // 50 MHz clock
  logic                  rst_i;       // Power-on reset
  logic [RCC_ADDR_W-1:0] addr_i;      // Bus address
  logic [7:0]            wdata_i;     // Bus write data
  logic                  wr_i;        // Write strobe
  logic                  rd_i;        // Read strobe
  logic [7:0]            rdata_o;     // Bus read data
  logic [1:0]            cfg;         // Brown-out configuration
  logic                  bo_i;        // Brown-out reset pulse
  logic                  ri_i;        // Reset instruction pulse
  logic                  or_i;        // Other reset pulse
  logic                  wt_i;        // Watchdog time-out pulse
  logic                  wc_i;        // Watchdog clear pulse
  logic                  sl_i;        // Sleep pulse
  logic                  prio_o;      // Priority levels output
  logic                  bden_o;      // Brown-out detect output
  bit   [7:0]            ms;          // Model image, bit 6 stored unmasked
  int                    seed;        // Random seed
  int                    mismatches;  // Failed compares
  int                    samples_checked;  // All compares
  int                    cycles;      // Hang guard

  rcc_reset_cause_control i_rcc_reset_cause_control (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .brownout_config_field_i(cfg),
    .brownout_reset_i(bo_i), .reset_instruction_i(ri_i), .other_reset_i(or_i),
    .watchdog_timeout_i(wt_i), .watchdog_clear_instruction_i(wc_i),
    .sleep_instruction_i(sl_i), .priority_levels_enable_o(prio_o),
    .brownout_detect_enable_o(bden_o));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; ceiling is well above the ~3000 cycles the tests need
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare with case inequality so unknowns never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Reset held 12 cycles; all pulses idle so the model starts clean
  task automatic do_reset();
    @(posedge sys_clk_i);
    {rst_i, wr_i, rd_i, bo_i, ri_i, or_i, wt_i, wc_i, sl_i} <= 9'h100;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    ms = 8'h5C;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One cycle: model takes the inputs seen at this edge, then new ones are driven
  // Directed mode: op 1 writes d, 2 reads, 3 pulses brown-out, 0 idles
  task automatic step(input bit ev, input bit dir, input bit [1:0] op, input logic [7:0] d);
    logic [7:0] exp_rd;
    int         r;
    bit         pon;
    exp_rd = 8'h00;
    @(posedge sys_clk_i);
    pon = ms[1];  // Brown-out keeps the flag even over a write
    // Read returns the image before any same-edge update
    if (rd_i && addr_i == RCC_REG_ADDR) exp_rd = {ms[7], ms[6] & (cfg == 2'h1), 1'b0, ms[4:0]};
    if (wr_i && addr_i == RCC_REG_ADDR)
      ms = {wdata_i[7:6], 1'b0, wdata_i[4], ms[3:2], wdata_i[1:0]};
    // Later lines win, matching the event priority
    if (wc_i) ms[3:2] = 2'b11;
    if (sl_i) ms[3:2] = 2'b10;
    if (wt_i) ms[3] = 1'b0;
    if (or_i || ri_i) ms[7] = 1'b0;
    if (ri_i) ms[4] = 1'b0;
    if (bo_i) ms = {3'b010, 3'b111, pon, 1'b0};
    r = $random(seed);
    if (dir) begin
      wr_i    <= (op == 2'h1);
      rd_i    <= (op == 2'h2);
      bo_i    <= (op == 2'h3);
      addr_i  <= RCC_REG_ADDR;
      wdata_i <= d;
      cfg     <= RCC_CFG_SW;
      {ri_i, or_i, wt_i, wc_i, sl_i} <= 5'h00;
    end else begin
      // One draw for both strobes so they never rise together
      wr_i    <= ((r & 3) == 1);
      rd_i    <= ((r & 3) >= 2);
      addr_i  <= (($random(seed) & 7) == 0) ? 4'h9 : RCC_REG_ADDR;
      wdata_i <= 8'($random(seed));
      cfg     <= 2'($random(seed));
      bo_i    <= ev && (($random(seed) & 63) == 0);
      ri_i    <= ev && (($random(seed) & 15) == 0);
      or_i    <= ev && (($random(seed) & 15) == 0);
      wt_i    <= ev && (($random(seed) & 15) == 0);
      wc_i    <= ev && (($random(seed) & 15) == 0);
      sl_i    <= ev && (($random(seed) & 15) == 0);
    end
    #1;
    chk(rdata_o, exp_rd);
    chk({7'h00, prio_o}, {7'h00, ms[7]});
    chk({7'h00, bden_o}, {7'h00, ms[6] & (cfg == 2'h1)});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: directed brown-out check, bus only, then events, then a reset in mid-run
  initial begin
    seed = 32'h205B;
    {mismatches, samples_checked, cycles} = '0;
    {rst_i, addr_i, wdata_i, wr_i, rd_i, cfg} = {1'b1, 16'h0000};
    {bo_i, ri_i, or_i, wt_i, wc_i, sl_i} = 6'h0;
    do_reset();
    // Firmware arms both cause flags, then tells a brown-out apart
    step(1'b0, 1'b1, 2'h1, 8'h13);
    step(1'b0, 1'b1, 2'h2, 8'h00);
    step(1'b0, 1'b1, 2'h3, 8'h00);
    chk({6'h00, rdata_o[1:0]}, 8'h03);
    step(1'b0, 1'b1, 2'h2, 8'h00);
    step(1'b0, 1'b1, 2'h0, 8'h00);
    chk({6'h00, rdata_o[1:0]}, 8'h02);
    $display("test brownout_decode done");
    repeat (300) step(1'b0, 1'b0, 2'h0, 8'h00);
    $display("test bus_only done");
    repeat (2000) step(1'b1, 1'b0, 2'h0, 8'h00);
    $display("test events done");
    do_reset();
    repeat (500) step(1'b1, 1'b0, 2'h0, 8'h00);
    $display("test second_reset done");
    stop_test();
  end
endmodule // rcc_reset_cause_control_bench

`default_nettype wire
